// File: sim/fault_log_and_rail_profile_cmds_tb.sv
`timescale 1ns/10ps
// ==========================================
// Command engine testbench
module fault_log_and_rail_profile_cmds_tb;
	logic sys_clk;
	logic rst_b;
	logic [7:0] regAddr;
	logic [7:0] regWrData;
	logic regWrStb;
	logic regRdStb;
	logic [7:0] regRdData;
	logic cmdNack;
	logic cmdDone;
	logic [4:0] page;
	logic [255:0] warnFlat;
	logic [15:0] railVolt;
	logic [15:0] railCurr;
	logic [15:0] railTemp;
	logic [3:0] railState;
	logic profPin;
	logic [1:0] accessProfile;
	logic [1:0] activeProfile;
	int bad_count = 0;
	int compares = 0;
	int nacks = 0;
	int dones = 0;
	int cycles = 0;
	localparam logic [7:0] PRF = flrp_pkg::CMD_RAIL_PROFILE;

	flrp_cmd_engine flrp_cmd_engine_i (.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr),
		.regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData),
		.cmdNack(cmdNack), .cmdDone(cmdDone), .page(page), .warnFlat(warnFlat),
		.railVolt(railVolt), .railCurr(railCurr), .railTemp(railTemp), .railState(railState),
		.general_input_pin(profPin), .accessProfile(accessProfile), .activeProfile(activeProfile));
	flrp_host_model flrp_host_model_i (.sys_clk(sys_clk), .regRdData(regRdData),
		.regAddr(regAddr), .regWrData(regWrData), .regWrStb(regWrStb), .regRdStb(regRdStb));

	always #12.5 sys_clk = ~sys_clk;
	// Nack counter and run-time ceiling
	always @(posedge sys_clk) begin
		cycles++;
		if (cmdNack === 1'b1) nacks++;
		if (cmdDone === 1'b1) dones++;
		if (cycles == 20000) begin
			bad_count++;
			final_report();
		end
	end
	task automatic chk(input string nm, input logic [7:0] exp, input logic [7:0] got);
		compares++;
		if (got !== exp) begin
			bad_count++;
			$display("[FAIL] %s expected %h seen %h", nm, exp, got);
		end
	endtask : chk
	task automatic rdb(input string nm, input logic [7:0] exp);
		logic [7:0] d;
		flrp_host_model_i.rd(8'h01, d);
		chk(nm, exp, d);
	endtask : rdb
	// Code, up to two payload bytes, then nack count
	task automatic cmd(input logic [4:0] pg, input logic [7:0] c, input int np,
		input logic [7:0] p0, input logic [7:0] p1, input logic expN);
		int n0;
		int d0;
		@(posedge sys_clk);
		page <= pg;
		@(negedge sys_clk);
		n0 = nacks;
		d0 = dones;
		flrp_host_model_i.wr(8'h00, c);
		if (np > 0) flrp_host_model_i.wr(8'h01, p0);
		if (np > 1) flrp_host_model_i.wr(8'h01, p1);
		repeat (2) @(posedge sys_clk);
		chk("nack", {7'h00, expN}, 8'(nacks - n0));
		chk("done", {7'h00, (expN || np == 2)}, 8'(dones - d0));
	endtask : cmd
	task automatic final_report();
		$display("checks %0d mismatches %0d", compares, bad_count);
		if (bad_count == 0 && compares > 0) begin
			$display("TB: PASS");
		end else begin
			$display("TB: FAIL");
		end
		$finish;
	endtask : final_report
	// Main sequence
	initial begin
		logic [55:0] v;
		logic [7:0] d;
		sys_clk = 1'b0;
		rst_b = 1'b0;
		page = 5'h00;
		profPin = 1'b0;
		railVolt = 16'h1234;
		railCurr = 16'hA55A;
		railTemp = 16'h0FE1;
		railState = 4'h1;
		for (int i = 0; i < 32; i++) begin
			warnFlat[8 * i +: 8] = 8'(8'h1B + i * 29);
		end
		repeat (10) @(posedge sys_clk);
		rst_b <= 1'b1;
		cmd(5'h00, flrp_pkg::CMD_RAILS_WARN, 0, 8'h00, 8'h00, 1'b0);
		for (int i = 0; i < 32; i++) begin
			rdb("warn", warnFlat[8 * i +: 8] & flrp_pkg::WB_VALID_MASK);
		end
		rdb("warn count", 8'h20);
		cmd(5'h03, flrp_pkg::CMD_RAIL_VALUE, 0, 8'h00, 8'h00, 1'b0);
		v = {railTemp, railCurr, railVolt, warnFlat[31:24] & flrp_pkg::WB_VALID_MASK};
		for (int i = 0; i < 7; i++) begin
			rdb("value", v[8 * i +: 8]);
		end
		rdb("value count", 8'h07);
		for (int s = 1; s < 9; s++) begin
			railState <= 4'(s);
			cmd(5'h05, flrp_pkg::CMD_RAIL_STATE, 0, 8'h00, 8'h00, 1'b0);
			rdb("state", 8'(s));
		end
		$display("test logs done");
		cmd(5'h00, flrp_pkg::CMD_RAILS_WARN, 1, 8'h00, 8'h00, 1'b1);
		cmd(5'h00, flrp_pkg::CMD_RAIL_VALUE, 1, 8'h00, 8'h00, 1'b1);
		cmd(5'h00, 8'hB5, 0, 8'h00, 8'h00, 1'b1);
		flrp_host_model_i.rd(8'h07, d);
		chk("unmapped", 8'h00, d);
		$display("test refusals done");
		cmd(5'h00, PRF, 2, 8'h05, 8'h00, 1'b1);
		cmd(5'h00, PRF, 2, 8'h02, 8'h02, 1'b1);
		cmd(5'h00, PRF, 2, 8'h02, 8'h01, 1'b0);
		chk("access", 8'h01, {6'h00, accessProfile});
		cmd(5'h00, PRF, 0, 8'h00, 8'h00, 1'b0);
		rdb("prof count", 8'h02);
		rdb("prof index", 8'h01);
		profPin <= 1'b1;
		repeat (4) @(negedge sys_clk);
		chk("active", 8'h01, {6'h00, activeProfile});
		cmd(5'h00, PRF, 0, 8'h00, 8'h00, 1'b0);
		rdb("prof count", 8'h02);
		rdb("prof index", 8'h11);
		cmd(5'h00, PRF, 2, 8'h01, 8'h00, 1'b1);
		cmd(5'h00, PRF, 2, 8'h00, 8'h02, 1'b1);
		cmd(5'h00, PRF, 2, 8'h00, 8'h04, 1'b1);
		cmd(5'h00, PRF, 2, 8'h00, 8'h00, 1'b0);
		chk("access", 8'h00, {6'h00, accessProfile});
		profPin <= 1'b0;
		$display("test profile done");
		for (int r = 1; r < 17; r++) begin
			cmd(5'(r), PRF, 2, 8'h04, 8'h03, 1'b0);
		end
		cmd(5'h11, PRF, 2, 8'h03, 8'h00, 1'b1);
		cmd(5'h11, PRF, 2, 8'h02, 8'h00, 1'b0);
		cmd(5'h12, PRF, 2, 8'h02, 8'h00, 1'b1);
		cmd(5'h01, PRF, 2, 8'h01, 8'h00, 1'b0);
		cmd(5'h12, PRF, 2, 8'h02, 8'h01, 1'b0);
		$display("test pool done");
		final_report();
	end
endmodule : fault_log_and_rail_profile_cmds_tb

// File: sim/flrp_cmd_properties.sv
`timescale 1ns/10ps
// ==========================================
// Command port checker
module flrp_cmd_properties (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	input wire logic [7:0] regRdData,
	input wire logic cmdNack,
	input wire logic cmdDone,
	input wire logic [4:0] page,
	input wire logic [255:0] warnFlat,
	input wire logic [3:0] railState,
	input wire logic [1:0] accessProfile
);
	default clocking cb @(posedge sys_clk); endclocking
	default disable iff (!rst_b);
	logic [7:0] code_q;
	logic fresh_q;
	logic [4:0] pg_q;
	logic [4:0] pg2_q;
	// Last code written, flag cleared by any later strobe other than a code write
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			code_q <= 8'h00;
			fresh_q <= 1'b0;
		end else if (regWrStb && regAddr == 8'h00) begin
			code_q <= regWrData;
			fresh_q <= 1'b1;
		end else if (regWrStb || regRdStb) begin
			fresh_q <= 1'b0;
		end
	end
	// Page history, selection may follow a page change
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			pg_q <= 5'h00;
			pg2_q <= 5'h00;
		end else begin
			pg_q <= page;
			pg2_q <= pg_q;
		end
	end
	property p_nack_done;
		cmdNack |-> cmdDone;
	endproperty
	a_nack_done: assert property (p_nack_done) else $error("nack without done");
	property p_done_cause;
		cmdDone |-> $past(regWrStb) || $past(regRdStb);
	endproperty
	a_done_cause: assert property (p_done_cause) else $error("done without strobe");
	property p_bad_code;
		regWrStb && regAddr == 8'h00 && !(regWrData inside {[8'hB6:8'hB9]}) |=> cmdNack && cmdDone;
	endproperty
	a_bad_code: assert property (p_bad_code) else $error("unknown code accepted");
	property p_log_write;
		regWrStb && fresh_q && regAddr == 8'h01 && code_q inside {8'hB6, 8'hB7, 8'hB9} |=> cmdNack;
	endproperty
	a_log_write: assert property (p_log_write) else $error("log write accepted");
	property p_rd_hold;
		!$stable(regRdData) |-> $past(regRdStb);
	endproperty
	a_rd_hold: assert property (p_rd_hold) else $error("read data moved");
	property p_unmapped;
		regRdStb && regAddr > 8'h01 |=> regRdData == 8'h00;
	endproperty
	a_unmapped: assert property (p_unmapped) else $error("unmapped read not zero");
	property p_state_rd;
		regRdStb && fresh_q && regAddr == 8'h01 && code_q == 8'hB9 |=> regRdData == {4'h0, $past(railState)};
	endproperty
	a_state_rd: assert property (p_state_rd) else $error("state byte wrong");
	property p_warn_rd;
		regRdStb && fresh_q && regAddr == 8'h01 && code_q == 8'hB6 |=> regRdData == ($past(warnFlat[7:0]) & 8'hE6);
	endproperty
	a_warn_rd: assert property (p_warn_rd) else $error("first warning byte wrong");
	property p_access;
		!$stable(accessProfile) |-> (cmdDone && !cmdNack) || page != pg2_q;
	endproperty
	a_access: assert property (p_access) else $error("selection moved alone");
	c_nack: cover property (cmdNack);
	c_ok: cover property (cmdDone && !cmdNack);
	c_prof: cover property (accessProfile != 2'h0);
endmodule : flrp_cmd_properties

bind flrp_cmd_engine flrp_cmd_properties flrp_cmd_properties_i (
	.sys_clk(sys_clk), .rst_b(rst_b), .regAddr(regAddr), .regWrData(regWrData),
	.regWrStb(regWrStb), .regRdStb(regRdStb), .regRdData(regRdData), .cmdNack(cmdNack),
	.cmdDone(cmdDone), .page(page), .warnFlat(warnFlat), .railState(railState),
	.accessProfile(accessProfile)
);

// File: sim/flrp_host_model.sv
`timescale 1ns/10ps
// ==========================================
// Host side of the command port
module flrp_host_model (
	input wire logic sys_clk,
	input wire logic [7:0] regRdData,
	output logic [7:0] regAddr,
	output logic [7:0] regWrData,
	output logic regWrStb,
	output logic regRdStb
);
	// Idle bus at time zero
	initial begin
		regAddr = 8'h00;
		regWrData = 8'h00;
		regWrStb = 1'b0;
		regRdStb = 1'b0;
	end
	// One write cycle, idle lines inverted afterwards
	task automatic wr(input logic [7:0] a, input logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regWrData <= d;
		regWrStb <= 1'b1;
		@(posedge sys_clk);
		regWrStb <= 1'b0;
		regAddr <= ~a;
		regWrData <= ~d;
	endtask : wr
	// One read cycle, data taken in the following cycle
	task automatic rd(input logic [7:0] a, output logic [7:0] d);
		@(posedge sys_clk);
		regAddr <= a;
		regRdStb <= 1'b1;
		@(posedge sys_clk);
		regRdStb <= 1'b0;
		regAddr <= ~a;
		@(negedge sys_clk);
		d = regRdData;
	endtask : rd
endmodule : flrp_host_model

// File: verilog/flrp_cmd_engine.sv
// The address map and the plain strobed port are this design's own decisions.
`timescale 1ns/10ps
// Function
// RULE1 - Rails warning block read, 32 bytes
// RULE2 - Warning bits: OV7 UV6 OC5 off-time2 OT1
// RULE3 - Rail one first, same layout each
// RULE4 - Paged value block read, 7 bytes
// RULE5 - Warning then voltage, current, temperature, low first
// RULE6 - Profile command selects accessed profile
// RULE7 - Read byte two: active high, selected low
// RULE8 - Count zero: select index, NACK if too big
// RULE9 - Count one-four grows or shrinks profiles
// RULE10 - NACK deleting the profile in use
// RULE11 - NACK index not below new count
// RULE12 - NACK counts above four
// RULE13 - Read byte one: profile count
// RULE14 - Fifty shared pool, NACK when exhausted
// RULE15 - Profile indices zero to three
// RULE16 - Input pin chooses active profile
// RULE17 - Host reloads counts with new project
// RULE18 - Paged rail state block read
// RULE19 - State codes idle1 through ramp-down8
// RULE20 - NACK writes to log commands
module flrp_cmd_engine (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic [7:0] regAddr,
	input wire logic [7:0] regWrData,
	input wire logic regWrStb,
	input wire logic regRdStb,
	output logic [7:0] regRdData,
	output logic cmdNack,
	output logic cmdDone,
	input wire logic [4:0] page,
	input wire logic [255:0] warnFlat,
	input wire logic [15:0] railVolt,
	input wire logic [15:0] railCurr,
	input wire logic [15:0] railTemp,
	input wire logic [3:0] railState,
	input wire logic general_input_pin,
	output logic [1:0] accessProfile,
	output logic [1:0] activeProfile
);
	// ==========================================
	// Command port decode
	// regAddr selects code or data; a write of the code to ADDR_CMD opens a command,
	// following writes or reads carry payload bytes in order.
	localparam logic [7:0] ADDR_CMD = 8'h00;
	localparam logic [7:0] ADDR_DATA = 8'h01;

	flrp_pkg::flrp_cmd_state_t state_q;
	logic [7:0] cmd_q;
	logic [4:0] idx_q;
	logic [7:0] wCount_q;
	logic [2:0] profCnt_q [flrp_pkg::NUM_RAILS];
	logic [1:0] profSel_q [flrp_pkg::NUM_RAILS];
	logic [5:0] poolUsed_q;
	logic [7:0] rdByte;
	logic pinLevel;
	logic isCmd;
	logic isData;
	logic [7:0] cmdLen;
	logic [2:0] curCnt;
	logic [1:0] curActive;
	logic [3:0] newCnt;
	logic [1:0] newIdx;
	logic accept;
	logic rejectWr;

	// Byte count per known command
	function automatic logic [7:0] blockLen(input logic [7:0] c);
		case (c)
			flrp_pkg::CMD_RAILS_WARN: blockLen = flrp_pkg::CNT_RAILS_WARN;
			flrp_pkg::CMD_RAIL_VALUE: blockLen = flrp_pkg::CNT_RAIL_VALUE;
			flrp_pkg::CMD_RAIL_PROFILE: blockLen = flrp_pkg::CNT_RAIL_PROFILE;
			flrp_pkg::CMD_RAIL_STATE: blockLen = flrp_pkg::CNT_RAIL_STATE;
			default: blockLen = 8'h00;
		endcase
	endfunction : blockLen

	// ==========================================
	// Profile switch pin
	flrp_sync uPinSync (
		.sys_clk(sys_clk),
		.rst_b(rst_b),
		.pinIn(general_input_pin),
		.pinSync(pinLevel)
	);

	assign isCmd = regWrStb && (regAddr == ADDR_CMD);
	assign isData = regAddr == ADDR_DATA;
	assign cmdLen = blockLen(cmd_q);
	assign curCnt = profCnt_q[page];

	// Pin asserted picks the top profile, deasserted the first
	assign curActive = pinLevel ? 2'(curCnt - 3'h1) : 2'h0; // RULE16 RULE15
	assign activeProfile = curActive;
	assign accessProfile = profSel_q[page]; // RULE6

	// ==========================================
	// Profile write check
	assign newCnt = wCount_q[3:0];
	assign newIdx = regWrData[1:0];
	always_comb begin
		accept = 1'b0;
		if (wCount_q == 8'h00) begin
			accept = (regWrData[7:2] == 6'h00) && ({1'b0, newIdx} < curCnt); // RULE8 RULE15
		end else if (wCount_q <= {4'h0, flrp_pkg::PROF_MAX}) begin // RULE12
			accept = (regWrData[7:2] == 6'h00) && ({2'h0, newIdx} < newCnt) // RULE11
				&& ({2'h0, curActive} < newCnt) // RULE10
				&& ((newCnt <= {1'b0, curCnt})
				|| ({2'h0, poolUsed_q} + 8'(newCnt) - 8'(curCnt)
				<= {2'h0, flrp_pkg::POOL_SIZE})); // RULE14
		end
	end

	// Writes into a read-only log command are refused
	assign rejectWr = (cmd_q == flrp_pkg::CMD_RAILS_WARN)
		|| (cmd_q == flrp_pkg::CMD_RAIL_VALUE)
		|| (cmd_q == flrp_pkg::CMD_RAIL_STATE); // RULE20

	// ==========================================
	// Command sequencing
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			state_q <= flrp_pkg::ST_IDLE;
			cmd_q <= 8'h00;
			idx_q <= 5'h00;
			wCount_q <= 8'h00;
		end else begin
			if (isCmd) begin
				cmd_q <= regWrData;
				idx_q <= 5'h00;
				state_q <= (blockLen(regWrData) == 8'h00) ? flrp_pkg::ST_DONE
					: flrp_pkg::ST_WDATA;
			end else begin
				case (state_q)
					flrp_pkg::ST_IDLE: begin
						state_q <= flrp_pkg::ST_IDLE;
					end
					flrp_pkg::ST_WDATA, flrp_pkg::ST_RDATA: begin
						if (isData && regRdStb) begin
							state_q <= flrp_pkg::ST_RDATA;
							idx_q <= idx_q + 5'h01;
							if ({3'h0, idx_q} == cmdLen - 8'h01) begin
								state_q <= flrp_pkg::ST_DONE;
							end
						end else if (isData && regWrStb && state_q == flrp_pkg::ST_WDATA) begin
							if (rejectWr || cmd_q != flrp_pkg::CMD_RAIL_PROFILE) begin
								state_q <= flrp_pkg::ST_DONE;
							end else if (idx_q == 5'h00) begin
								wCount_q <= regWrData;
								idx_q <= 5'h01;
							end else begin
								state_q <= flrp_pkg::ST_DONE;
							end
						end
					end
					flrp_pkg::ST_DONE: begin
						state_q <= flrp_pkg::ST_DONE;
					end
					default: state_q <= flrp_pkg::ST_IDLE;
				endcase
			end
		end
	end

	// ==========================================
	// Completion and refusal flags, one cycle
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			cmdNack <= 1'b0;
			cmdDone <= 1'b0;
		end else begin
			cmdNack <= 1'b0;
			cmdDone <= 1'b0;
			if (isCmd && blockLen(regWrData) == 8'h00) begin
				cmdNack <= 1'b1;
				cmdDone <= 1'b1;
			end else if (!isCmd && isData && regWrStb && state_q == flrp_pkg::ST_WDATA) begin
				if (rejectWr) begin
					cmdNack <= 1'b1; // RULE20
					cmdDone <= 1'b1;
				end else if (cmd_q == flrp_pkg::CMD_RAIL_PROFILE && idx_q != 5'h00) begin
					cmdNack <= !accept; // RULE8 RULE10 RULE11 RULE12 RULE14
					cmdDone <= 1'b1;
				end
			end else if (!isCmd && isData && regRdStb
				&& (state_q == flrp_pkg::ST_WDATA || state_q == flrp_pkg::ST_RDATA)
				&& {3'h0, idx_q} == cmdLen - 8'h01) begin
				cmdDone <= 1'b1;
			end
		end
	end

	// ==========================================
	// Per rail profile tables
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			for (int i = 0; i < flrp_pkg::NUM_RAILS; i++) begin
				profCnt_q[i] <= flrp_pkg::PROF_CNT_RST;
				profSel_q[i] <= 2'h0;
			end
			poolUsed_q <= flrp_pkg::POOL_USED_RST;
		end else if (!isCmd && isData && regWrStb && state_q == flrp_pkg::ST_WDATA
			&& cmd_q == flrp_pkg::CMD_RAIL_PROFILE && idx_q != 5'h00 && accept) begin
			profSel_q[page] <= newIdx; // RULE6 RULE8
			if (wCount_q != 8'h00) begin
				profCnt_q[page] <= newCnt[2:0]; // RULE9
				// Pool tracks profiles above each rail's first
				poolUsed_q <= 6'(poolUsed_q + 6'(newCnt) - 6'(curCnt)); // RULE14
			end
		end
	end

	// ==========================================
	// Read data, valid the cycle after the strobe
	flrp_payload_mux uMux (
		.cmdCode(cmd_q),
		.byteIdx(idx_q),
		.warnFlat(warnFlat),
		.page(page),
		.railVolt(railVolt),
		.railCurr(railCurr),
		.railTemp(railTemp),
		.profCount(curCnt),
		.profActive(curActive),
		.profSel(profSel_q[page]),
		.railState(railState),
		.byteOut(rdByte)
	);

	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			regRdData <= 8'h00;
		end else if (regRdStb) begin
			if (regAddr == ADDR_CMD) begin
				regRdData <= cmd_q;
			end else if (isData && (state_q == flrp_pkg::ST_WDATA
				|| state_q == flrp_pkg::ST_RDATA)) begin
				regRdData <= rdByte; // RULE4 RULE2
			end else if (isData) begin
				regRdData <= cmdLen;
			end else begin
				regRdData <= 8'h00;
			end
		end
	end
endmodule : flrp_cmd_engine

// File: verilog/flrp_payload_mux.sv
`timescale 1ns/10ps
// ==========================================
// Read payload byte selection
module flrp_payload_mux (
	input wire logic [7:0] cmdCode,
	input wire logic [4:0] byteIdx,
	input wire logic [255:0] warnFlat,
	input wire logic [4:0] page,
	input wire logic [15:0] railVolt,
	input wire logic [15:0] railCurr,
	input wire logic [15:0] railTemp,
	input wire logic [2:0] profCount,
	input wire logic [1:0] profActive,
	input wire logic [1:0] profSel,
	input wire logic [3:0] railState,
	output logic [7:0] byteOut
);
	logic [7:0] pageWarn;

	// Paged rail warning, reserved bits forced to zero
	assign pageWarn = warnFlat[{page, 3'h0} +: 8] & flrp_pkg::WB_VALID_MASK;

	// Byte per command and index
	always_comb begin
		byteOut = 8'h00;
		case (cmdCode)
			flrp_pkg::CMD_RAILS_WARN: begin
				byteOut = warnFlat[{byteIdx, 3'h0} +: 8] & flrp_pkg::WB_VALID_MASK; // RULE1 RULE3
			end
			flrp_pkg::CMD_RAIL_VALUE: begin
				case (byteIdx)
					5'h00: byteOut = pageWarn; // RULE5
					5'h01: byteOut = railVolt[7:0];
					5'h02: byteOut = railVolt[15:8];
					5'h03: byteOut = railCurr[7:0];
					5'h04: byteOut = railCurr[15:8];
					5'h05: byteOut = railTemp[7:0];
					5'h06: byteOut = railTemp[15:8];
					default: byteOut = 8'h00;
				endcase
			end
			flrp_pkg::CMD_RAIL_PROFILE: begin
				if (byteIdx == 5'h00) begin
					byteOut = {5'h00, profCount}; // RULE13
				end else begin
					byteOut = {2'h0, profActive, 2'h0, profSel}; // RULE7
				end
			end
			flrp_pkg::CMD_RAIL_STATE: begin
				byteOut = {4'h0, railState}; // RULE18 RULE19
			end
			default: byteOut = 8'h00;
		endcase
	end
endmodule : flrp_payload_mux

// File: verilog/flrp_pkg.sv
package flrp_pkg;

	// ==========================================
	// Command codes
	localparam logic [7:0] CMD_RAILS_WARN = 8'hB6;
	localparam logic [7:0] CMD_RAIL_VALUE = 8'hB7;
	localparam logic [7:0] CMD_RAIL_PROFILE = 8'hB8;
	localparam logic [7:0] CMD_RAIL_STATE = 8'hB9;

	// ==========================================
	// Block byte counts
	localparam logic [7:0] CNT_RAILS_WARN = 8'h20;
	localparam logic [7:0] CNT_RAIL_VALUE = 8'h07;
	localparam logic [7:0] CNT_RAIL_PROFILE = 8'h02;
	localparam logic [7:0] CNT_RAIL_STATE = 8'h01;

	// ==========================================
	// Rail and profile sizing
	localparam int NUM_RAILS = 32;
	localparam int PAGE_W = 5;
	localparam logic [3:0] PROF_MAX = 4'h4;
	localparam logic [5:0] POOL_SIZE = 6'h32;
	localparam logic [1:0] PROF_IDX_MAX = 2'h3;

	// ==========================================
	// Warning byte bit positions
	localparam int WB_OV = 7;
	localparam int WB_UV = 6;
	localparam int WB_OC = 5;
	localparam int WB_TOFF = 2;
	localparam int WB_OT = 1;
	localparam logic [7:0] WB_VALID_MASK = 8'hE6;

	// ==========================================
	// Rail state codes
	typedef enum logic [3:0] {
		RS_IDLE = 4'h1,
		RS_SEQ_ON = 4'h2,
		RS_ON_DELAY = 4'h3,
		RS_RAMP_UP = 4'h4,
		RS_REGULATION = 4'h5,
		RS_SEQ_OFF = 4'h6,
		RS_OFF_DELAY = 4'h7,
		RS_RAMP_DOWN = 4'h8
	} flrp_rail_state_t;

	// ==========================================
	// Command engine states
	typedef enum logic [3:0] {
		ST_IDLE = 4'b0001,
		ST_WDATA = 4'b0010,
		ST_RDATA = 4'b0100,
		ST_DONE = 4'b1000
	} flrp_cmd_state_t;

	// ==========================================
	// Reset values
	localparam logic [2:0] PROF_CNT_RST = 3'h1;
	localparam logic [5:0] POOL_USED_RST = 6'h00;

endpackage : flrp_pkg

// File: verilog/flrp_sync.sv
`timescale 1ns/10ps
// ==========================================
// Two flip-flop synchroniser for pin levels
module flrp_sync (
	input wire logic sys_clk,
	input wire logic rst_b,
	input wire logic pinIn,
	output logic pinSync
);
	logic meta_q;

	// First stage read only by second stage
	always_ff @(posedge sys_clk or negedge rst_b) begin
		if (!rst_b) begin
			meta_q <= 1'b0;
			pinSync <= 1'b0;
		end else begin
			meta_q <= pinIn;
			pinSync <= meta_q;
		end
	end
endmodule : flrp_sync
